// ===== hdl/drop_monitor_pkg.sv
// Constants shared by the supply drop detector control and its sample timer.
// Assumes a single 100 MHz system clock and a 32-bit AXI4-Lite register port.
package drop_monitor_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned CLK_PERIOD_NS = 10;
   // Sample rates selectable by sampling_rate_select.
   localparam int unsigned FAST_RATE_HZ = 1000;
   localparam int unsigned SLOW_RATE_HZ = 125;
   localparam int unsigned FAST_PERIOD_CYC = CLK_HZ / FAST_RATE_HZ;
   localparam int unsigned SLOW_PERIOD_CYC = CLK_HZ / SLOW_RATE_HZ;
   // Time the comparator is powered per sample, and its settling time.
   localparam int unsigned SAMPLE_ON_NS = 80;
   localparam int unsigned SAMPLE_ON_CYC = (SAMPLE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_NS = 100;
   localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMER_W = 20;
   // Register indices; byte address is four times the index.
   localparam logic [3:0] IDX_CTRL_A = 4'h0;
   localparam logic [3:0] IDX_CTRL_B = 4'h1;
   localparam logic [3:0] IDX_WATCH_CTRL = 4'h8;
   localparam logic [3:0] IDX_IRQ_CTRL = 4'h9;
   localparam logic [3:0] IDX_IRQ_FLAGS = 4'hA;
   localparam logic [3:0] IDX_STATUS = 4'hB;
   localparam logic [3:0] IDX_UNLOCK = 4'hF;
   localparam int unsigned ADDR_W = 6;
   // Field positions.
   localparam int unsigned SAMP_BIT = 4;
   localparam int unsigned ACTIVE_LSB = 2;
   localparam int unsigned SLEEP_LSB = 0;
   localparam int unsigned TRIG_LSB = 1;
   localparam int unsigned IE_BIT = 0;
   localparam int unsigned FLAG_BIT = 0;
   localparam int unsigned STATUS_BIT = 0;
   // Reset values of software-only fields.
   localparam logic [1:0] WATCH_LVL_RST = 2'h0;
   localparam logic [1:0] TRIG_RST = 2'h0;
   // Unlock key value is arbitrary; window length is counted in clock cycles.
   localparam logic [7:0] UNLOCK_KEY = 8'hA5;
   localparam logic [4:0] UNLOCK_WINDOW_CYC = 5'h10;
   typedef enum logic [1:0] {
      MODE_OFF = 2'h0, MODE_CONT = 2'h1, MODE_SAMPLED = 2'h2, MODE_HALT_WAKE = 2'h3
   } mode_t;
   typedef enum logic [1:0] {
      TRIG_BELOW = 2'h0, TRIG_ABOVE = 2'h1, TRIG_CROSS = 2'h2
   } trig_t;
   localparam logic [1:0] LVL_RESERVED = 2'h3;
   localparam logic [1:0] TRIG_RESERVED = 2'h3;
   typedef enum logic [2:0] {
      DET_OFF = 3'b001, DET_SETTLE = 3'b010, DET_ON = 3'b100
   } det_state_t;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/sample_if.sv
// Signals between the detector control and its sample timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface sample_if;
   logic run;
   logic rate_slow;
   logic window;
   logic take;
   modport timer (input run, input rate_slow, output window, output take);
   modport user (output run, output rate_slow, input window, input take);
endinterface

// ===== hdl/sample_timer.sv
// Period divider for sampled mode: powers the comparator briefly each period.
// Assumes run and rate_slow are synchronous to clk.
`timescale 1ns/10ps
module sample_timer #(
   parameter int unsigned FAST_PERIOD = drop_monitor_pkg::FAST_PERIOD_CYC,
   parameter int unsigned SLOW_PERIOD = drop_monitor_pkg::SLOW_PERIOD_CYC,
   parameter int unsigned ON_CYC = drop_monitor_pkg::SAMPLE_ON_CYC
) (
   input wire logic clk,
   input wire logic srst,
   sample_if.timer sif
);
   localparam int unsigned W = drop_monitor_pkg::TIMER_W;
   logic [W-1:0] count_q;
   logic [W-1:0] count_d;
   logic [W-1:0] last;
   logic at_end;

   assign last = sif.rate_slow ? W'(SLOW_PERIOD - 1) : W'(FAST_PERIOD - 1);
   assign at_end = count_q >= last;
   // The comparator is powered during the final cycles of each period.
   assign sif.window = sif.run && (count_q >= last - W'(ON_CYC - 1));
   assign sif.take = sif.run && at_end;
   assign count_d = (!sif.run || at_end) ? '0 : count_q + W'(1);

   always_ff @(posedge clk) begin
      if (srst) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end
endmodule // sample_timer

// ===== hdl/drop_monitor_ctrl.sv
// Supply drop detector and voltage level watch control with AXI4-Lite registers.
// Assumes analog comparators drive supply_below_* synchronously to clk, and
// that the power manager drives deep_sleep high in standby or power-down.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module drop_monitor_ctrl #(
   parameter int unsigned FAST_PERIOD = drop_monitor_pkg::FAST_PERIOD_CYC,
   parameter int unsigned SLOW_PERIOD = drop_monitor_pkg::SLOW_PERIOD_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] fuse_drop_level,
   input wire logic [1:0] fuse_run_mode,
   input wire logic [1:0] fuse_sleep_mode,
   input wire logic fuse_sampling_rate,
   input wire logic deep_sleep,
   input wire logic debug_halt,
   input wire logic supply_below_drop,
   input wire logic supply_below_watch,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic detector_power,
   output logic [2:0] drop_level_code,
   output logic [1:0] watch_level_code,
   output logic system_reset_req,
   output logic irq,
   output logic cpu_hold
);
   // Configuration and status registers.
   logic [2:0] drop_level_q;
   logic [1:0] run_mode_q;
   logic [1:0] sleep_mode_q;
   logic sampling_rate_select_q;
   logic [1:0] monitor_level_select_q;
   logic [1:0] monitor_trigger_select_q;
   logic monitor_irq_enable_q;
   logic monitor_irq_flag_q;
   logic watch_below_q;
   logic [4:0] unlock_cnt_q;
   // Detector control state.
   drop_monitor_pkg::det_state_t det_q;
   drop_monitor_pkg::det_state_t det_d;
   logic [3:0] settle_q;
   logic deep_prev_q;
   logic wake_hold_q;
   logic detector_power_q;
   logic reset_req_q;
   logic irq_q;
   logic cpu_hold_q;
   // Bus state.
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   sample_if sif ();

   sample_timer #(
      .FAST_PERIOD(FAST_PERIOD),
      .SLOW_PERIOD(SLOW_PERIOD),
      .ON_CYC(drop_monitor_pkg::SAMPLE_ON_CYC)
   ) u_timer (
      .clk(clk),
      .srst(srst),
      .sif(sif)
   );

   // Mode selection: deep sleep uses the low-power field, else the run field.
   logic [1:0] eff_mode;
   logic mode_cont;
   logic mode_sampled;
   logic detector_active;
   assign eff_mode = deep_sleep ? sleep_mode_q : run_mode_q;
   // The low-power field has no halt-at-wake code, so 3 there means disabled.
   assign mode_cont = (eff_mode == drop_monitor_pkg::MODE_CONT) ||
      (!deep_sleep && eff_mode == drop_monitor_pkg::MODE_HALT_WAKE);
   assign mode_sampled = eff_mode == drop_monitor_pkg::MODE_SAMPLED;
   assign detector_active = mode_cont || mode_sampled;
   assign sif.run = mode_sampled;
   assign sif.rate_slow = sampling_rate_select_q;

   // A comparison is taken every cycle once settled, or once per sample period.
   logic take;
   assign take = (mode_cont && det_q == drop_monitor_pkg::DET_ON) ||
      (mode_sampled && sif.take);

   // Continuous-mode power-up sequence.
   logic settle_done;
   assign settle_done = settle_q == 4'(drop_monitor_pkg::SETTLE_CYC - 1);
   always_comb begin
      det_d = det_q;
      case (det_q)
         drop_monitor_pkg::DET_OFF: begin
            if (mode_cont) det_d = drop_monitor_pkg::DET_SETTLE;
         end
         drop_monitor_pkg::DET_SETTLE: begin
            if (!mode_cont) det_d = drop_monitor_pkg::DET_OFF;
            else if (settle_done) det_d = drop_monitor_pkg::DET_ON;
         end
         drop_monitor_pkg::DET_ON: begin
            if (!mode_cont) det_d = drop_monitor_pkg::DET_OFF;
         end
         default: det_d = drop_monitor_pkg::DET_OFF;
      endcase
   end

   // Level watch: active only when enabled and the detector is running.
   logic watch_active;
   logic crossed_down;
   logic crossed_up;
   logic crossing;
   assign watch_active = monitor_irq_enable_q && detector_active;
   assign crossed_down = supply_below_watch && !watch_below_q;
   assign crossed_up = !supply_below_watch && watch_below_q;
   always_comb begin
      case (monitor_trigger_select_q)
         drop_monitor_pkg::TRIG_BELOW: crossing = crossed_down;
         drop_monitor_pkg::TRIG_ABOVE: crossing = crossed_up;
         drop_monitor_pkg::TRIG_CROSS: crossing = crossed_down || crossed_up;
         default: crossing = 1'b0;
      endcase
   end
   logic flag_set;
   assign flag_set = watch_active && take && crossing;

   // Register write decode.
   logic wr_fire;
   logic rd_fire;
   logic [3:0] wr_idx;
   logic [3:0] rd_idx;
   logic wr_lane0;
   logic [7:0] wbyte;
   logic unlocked;
   assign wr_fire = awready_q && s_axi_awvalid && wready_q && s_axi_wvalid;
   assign rd_fire = arready_q && s_axi_arvalid;
   assign wr_idx = s_axi_awaddr[5:2];
   assign rd_idx = s_axi_araddr[5:2];
   assign wr_lane0 = wr_fire && s_axi_wstrb[0];
   assign wbyte = s_axi_wdata[7:0];
   assign unlocked = unlock_cnt_q != 5'h0;
   logic wr_ctrl_a;
   logic wr_watch;
   logic wr_irqctl;
   logic wr_flags;
   logic wr_unlock;
   assign wr_ctrl_a = wr_lane0 && wr_idx == drop_monitor_pkg::IDX_CTRL_A;
   assign wr_watch = wr_lane0 && wr_idx == drop_monitor_pkg::IDX_WATCH_CTRL;
   assign wr_irqctl = wr_lane0 && wr_idx == drop_monitor_pkg::IDX_IRQ_CTRL;
   assign wr_flags = wr_lane0 && wr_idx == drop_monitor_pkg::IDX_IRQ_FLAGS;
   assign wr_unlock = wr_lane0 && wr_idx == drop_monitor_pkg::IDX_UNLOCK;
   logic [1:0] new_sleep;
   logic [1:0] new_level;
   logic [1:0] new_trig;
   assign new_sleep = wbyte[drop_monitor_pkg::SLEEP_LSB +: 2];
   assign new_level = wbyte[1:0];
   assign new_trig = wbyte[drop_monitor_pkg::TRIG_LSB +: 2];
   logic wr_mapped;
   assign wr_mapped = wr_idx <= drop_monitor_pkg::IDX_CTRL_B ||
      (wr_idx >= drop_monitor_pkg::IDX_WATCH_CTRL && wr_idx <= drop_monitor_pkg::IDX_STATUS) ||
      wr_idx == drop_monitor_pkg::IDX_UNLOCK;

   // Register read multiplexer; unused bits read as zero.
   logic [7:0] rd_byte;
   logic rd_mapped;
   always_comb begin
      rd_byte = 8'h00;
      rd_mapped = 1'b1;
      case (rd_idx)
         drop_monitor_pkg::IDX_CTRL_A: begin
            rd_byte[drop_monitor_pkg::SAMP_BIT] = sampling_rate_select_q;
            rd_byte[drop_monitor_pkg::ACTIVE_LSB +: 2] = run_mode_q;
            rd_byte[drop_monitor_pkg::SLEEP_LSB +: 2] = sleep_mode_q;
         end
         drop_monitor_pkg::IDX_CTRL_B: rd_byte[2:0] = drop_level_q;
         drop_monitor_pkg::IDX_WATCH_CTRL: rd_byte[1:0] = monitor_level_select_q;
         drop_monitor_pkg::IDX_IRQ_CTRL: begin
            rd_byte[drop_monitor_pkg::TRIG_LSB +: 2] = monitor_trigger_select_q;
            rd_byte[drop_monitor_pkg::IE_BIT] = monitor_irq_enable_q;
         end
         drop_monitor_pkg::IDX_IRQ_FLAGS: rd_byte[drop_monitor_pkg::FLAG_BIT] = monitor_irq_flag_q;
         drop_monitor_pkg::IDX_STATUS: rd_byte[drop_monitor_pkg::STATUS_BIT] = watch_below_q;
         drop_monitor_pkg::IDX_UNLOCK: rd_byte = 8'h00;
         default: rd_mapped = 1'b0;
      endcase
   end

   // Fuse-loaded configuration: captured on every reset cycle; afterwards only the low-power field changes, by a write while unlocked.
   always_ff @(posedge clk) begin
      if (srst) begin
         drop_level_q <= fuse_drop_level;
         run_mode_q <= fuse_run_mode;
         sleep_mode_q <= fuse_sleep_mode;
         sampling_rate_select_q <= fuse_sampling_rate;
      end else if (wr_ctrl_a && unlocked) begin
         sleep_mode_q <= new_sleep;
      end
   end

   // Software settings and the unlock window.
   always_ff @(posedge clk) begin
      if (srst) begin
         monitor_level_select_q <= drop_monitor_pkg::WATCH_LVL_RST;
         monitor_trigger_select_q <= drop_monitor_pkg::TRIG_RST;
         monitor_irq_enable_q <= 1'b0;
         unlock_cnt_q <= 5'h0;
      end else begin
         if (wr_watch && new_level != drop_monitor_pkg::LVL_RESERVED) begin
            monitor_level_select_q <= new_level;
         end
         if (wr_irqctl) begin
            monitor_irq_enable_q <= wbyte[drop_monitor_pkg::IE_BIT];
            if (new_trig != drop_monitor_pkg::TRIG_RESERVED) begin
               monitor_trigger_select_q <= new_trig;
            end
         end
         // The window closes after one protected write so a key opens one change.
         if (wr_unlock && wbyte == drop_monitor_pkg::UNLOCK_KEY) begin
            unlock_cnt_q <= drop_monitor_pkg::UNLOCK_WINDOW_CYC;
         end else if (wr_ctrl_a) begin
            unlock_cnt_q <= 5'h0;
         end else if (unlocked) begin
            unlock_cnt_q <= unlock_cnt_q - 5'h1;
         end
      end
   end

   // Watch status and flag; a crossing in the clearing cycle is kept.
   always_ff @(posedge clk) begin
      if (srst) begin
         watch_below_q <= 1'b0;
         monitor_irq_flag_q <= 1'b0;
      end else begin
         if (take) watch_below_q <= supply_below_watch;
         if (flag_set) monitor_irq_flag_q <= 1'b1;
         else if (wr_flags && wbyte[drop_monitor_pkg::FLAG_BIT]) monitor_irq_flag_q <= 1'b0;
      end
   end

   // Detector sequencing and the outputs it drives.
   always_ff @(posedge clk) begin
      if (srst) begin
         det_q <= drop_monitor_pkg::DET_OFF;
         settle_q <= 4'h0;
         deep_prev_q <= 1'b0;
         wake_hold_q <= 1'b0;
         detector_power_q <= 1'b0;
         reset_req_q <= 1'b0;
         irq_q <= 1'b0;
         cpu_hold_q <= 1'b0;
      end else begin
         det_q <= det_d;
         settle_q <= (det_q == drop_monitor_pkg::DET_SETTLE) ? settle_q + 4'h1 : 4'h0;
         deep_prev_q <= deep_sleep;
         if (deep_prev_q && !deep_sleep && run_mode_q == drop_monitor_pkg::MODE_HALT_WAKE) begin
            wake_hold_q <= 1'b1;
         end else if (det_q == drop_monitor_pkg::DET_ON || !mode_cont) begin
            wake_hold_q <= 1'b0;
         end
         cpu_hold_q <= (wake_hold_q || (deep_prev_q && !deep_sleep &&
            run_mode_q == drop_monitor_pkg::MODE_HALT_WAKE)) &&
            det_q != drop_monitor_pkg::DET_ON;
         detector_power_q <= mode_cont || (mode_sampled && sif.window);
         if (!detector_active) reset_req_q <= 1'b0;
         else if (take) reset_req_q <= supply_below_drop;
         irq_q <= monitor_irq_enable_q && monitor_irq_flag_q && !debug_halt;
      end
   end

   // AXI4-Lite slave: one write and one read in flight; ready pulses for one cycle.
   always_ff @(posedge clk) begin
      if (srst) begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= drop_monitor_pkg::RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= drop_monitor_pkg::RESP_OKAY;
      end else begin
         awready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
         wready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? drop_monitor_pkg::RESP_OKAY : drop_monitor_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
         if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= rd_mapped ? drop_monitor_pkg::RESP_OKAY : drop_monitor_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign detector_power = detector_power_q;
   assign drop_level_code = drop_level_q;
   assign watch_level_code = monitor_level_select_q;
   assign system_reset_req = reset_req_q;
   assign irq = irq_q;
   assign cpu_hold = cpu_hold_q;
endmodule // drop_monitor_ctrl

// ===== verification/drop_monitor_ctrl_checker.sv
// Concurrent checks on the ports of the supply drop detector control.
// Assumes one clock and a synchronous active-high reset; bound into every instance.
`timescale 1ns/10ps
module drop_monitor_ctrl_checker (
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] fuse_drop_level,
   input wire logic [1:0] fuse_run_mode,
   input wire logic deep_sleep,
   input wire logic debug_halt,
   input wire logic supply_below_drop,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic detector_power,
   input wire logic [2:0] drop_level_code,
   input wire logic system_reset_req,
   input wire logic irq,
   input wire logic cpu_hold
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   property p_fuse_load; $fell(srst) |-> drop_level_code == $past(fuse_drop_level); endproperty
   a_fuse_load: assert property (p_fuse_load) else $error("level not taken from fuse");
   property p_level_fixed; !$past(srst) |-> $stable(drop_level_code); endproperty
   a_level_fixed: assert property (p_level_fixed) else $error("level changed in run");
   property p_reset_cause;
      $rose(system_reset_req) |-> $past(supply_below_drop) || $past(supply_below_drop, 2);
   endproperty
   a_reset_cause: assert property (p_reset_cause) else $error("reset without drop");
   property p_irq_debug; debug_halt |=> !irq; endproperty
   a_irq_debug: assert property (p_irq_debug) else $error("irq while halted");
   // The flag only goes away by a bus write, so irq may only drop after one or a halt.
   property p_irq_fall;
      $fell(irq) |-> $past(debug_halt) || $past(s_axi_awready, 2) || $past(s_axi_awready, 3);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped on its own");
   property p_cont_power; (!deep_sleep && fuse_run_mode == 2'h1) [*4] |-> detector_power; endproperty
   a_cont_power: assert property (p_cont_power) else $error("continuous mode unpowered");
   property p_hold_rise; $rose(cpu_hold) |-> $past(deep_sleep, 2) || $past(deep_sleep, 3); endproperty
   a_hold_rise: assert property (p_hold_rise) else $error("hold without wake");
   property p_b_after; s_axi_awready |=> s_axi_bvalid && !s_axi_awready; endproperty
   a_b_after: assert property (p_b_after) else $error("write response late");
   property p_r_after; s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
   a_r_after: assert property (p_r_after) else $error("read response late");
   cover property (irq);
   cover property ($fell(cpu_hold));
   cover property ($rose(system_reset_req));
endmodule // drop_monitor_ctrl_checker

bind drop_monitor_ctrl drop_monitor_ctrl_checker chk (.clk, .srst, .fuse_drop_level,
   .fuse_run_mode, .deep_sleep, .debug_halt, .supply_below_drop, .s_axi_awready, .s_axi_bvalid,
   .s_axi_arready, .s_axi_rvalid, .detector_power, .drop_level_code, .system_reset_req, .irq,
   .cpu_hold);

// ===== verification/brownout_monitor_control_bench.sv
// Self-checking bench for the supply drop detector control.
// Assumes the checker is bound in; sample periods are shortened to 40 and 80 cycles.
`timescale 1ns/10ps
module brownout_monitor_control_bench;
   localparam logic [1:0] OK = drop_monitor_pkg::RESP_OKAY;
   localparam logic [1:0] ER = drop_monitor_pkg::RESP_SLVERR;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] fuse_drop_level = 3'h5;
   logic [1:0] fuse_run_mode = 2'h1;
   logic [1:0] fuse_sleep_mode = 2'h2;
   logic fuse_sampling_rate = 1'b1;
   logic deep_sleep = 1'b0;
   logic debug_halt = 1'b0;
   logic supply_below_drop = 1'b0;
   logic supply_below_watch = 1'b0;
   logic [5:0] s_axi_awaddr = 6'h00;
   logic [5:0] s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, watch_level_code;
   logic [31:0] s_axi_rdata;
   logic [2:0] drop_level_code;
   logic detector_power, system_reset_req, irq, cpu_hold;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   // Ready lines stay high: the bench never stalls a response.
   drop_monitor_ctrl #(.FAST_PERIOD(40), .SLOW_PERIOD(80)) DUT (.clk, .srst,
      .fuse_drop_level, .fuse_run_mode, .fuse_sleep_mode, .fuse_sampling_rate, .deep_sleep,
      .debug_halt, .supply_below_drop, .supply_below_watch, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
      .detector_power, .drop_level_code, .watch_level_code, .system_reset_req, .irq, .cpu_hold);
   always #5 clk = ~clk;
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         wrap_up;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk(s_axi_bresp, er);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
   endtask
   task automatic boot(input logic [1:0] run, input logic [1:0] slp, input logic rate);
      srst <= 1'b1;
      fuse_run_mode <= run;
      fuse_sleep_mode <= slp;
      fuse_sampling_rate <= rate;
      tick(20);
      srst <= 1'b0;
      tick(15);
   endtask
   task automatic t_regs;
      chk(drop_level_code, 32'h5);
      rd(6'h00, 32'h16, OK);
      wr(6'h04, 32'h2, OK);
      rd(6'h04, 32'h5, OK);
      wr(6'h00, 32'hFF, OK);
      rd(6'h00, 32'h16, OK);
      wr(6'h3C, 32'hA5, OK);
      wr(6'h00, 32'h1, OK);
      rd(6'h00, 32'h15, OK);
      wr(6'h20, 32'h1, OK);
      wr(6'h20, 32'h3, OK);
      rd(6'h20, 32'h1, OK);
      chk(watch_level_code, 32'h1);
      // Only the low byte lane carries a register, so a write without it must not act.
      s_axi_wstrb <= 4'h0;
      wr(6'h20, 32'h2, OK);
      s_axi_wstrb <= 4'hF;
      rd(6'h20, 32'h1, OK);
      rd(6'h10, 32'h0, ER);
      wr(6'h10, 32'h1, ER);
      $display("test regs done");
   endtask
   task automatic t_watch;
      for (int t = 0; t < 3; t++) begin
         wr(6'h24, {29'h0, t[1:0], 1'b1}, OK);
         wr(6'h28, 32'h1, OK);
         supply_below_watch <= 1'b1;
         tick(4);
         rd(6'h2C, 32'h1, OK);
         rd(6'h28, {31'h0, t != 1}, OK);
         chk(irq, {31'h0, t != 1});
         debug_halt <= 1'b1;
         tick(2);
         chk(irq, 32'h0);
         debug_halt <= 1'b0;
         wr(6'h28, 32'h0, OK);
         rd(6'h28, {31'h0, t != 1}, OK);
         wr(6'h28, 32'h1, OK);
         supply_below_watch <= 1'b0;
         tick(4);
         rd(6'h28, {31'h0, t != 0}, OK);
      end
      wr(6'h24, 32'h0, OK);
      wr(6'h28, 32'h1, OK);
      supply_below_watch <= 1'b1;
      tick(4);
      rd(6'h28, 32'h0, OK);
      supply_below_watch <= 1'b0;
      $display("test watch done");
   endtask
   task automatic t_drop;
      supply_below_drop <= 1'b1;
      tick(4);
      chk(system_reset_req, 32'h1);
      supply_below_drop <= 1'b0;
      tick(4);
      chk(system_reset_req, 32'h0);
      $display("test drop done");
   endtask
   task automatic t_sleep;
      boot(2'h0, 2'h1, 1'b0);
      chk(detector_power, 32'h0);
      wr(6'h24, 32'h1, OK);
      supply_below_watch <= 1'b1;
      tick(4);
      rd(6'h28, 32'h0, OK);
      supply_below_watch <= 1'b0;
      deep_sleep <= 1'b1;
      tick(4);
      chk(detector_power, 32'h1);
      deep_sleep <= 1'b0;
      tick(4);
      chk(detector_power, 32'h0);
      boot(2'h3, 2'h0, 1'b0);
      deep_sleep <= 1'b1;
      tick(4);
      chk(detector_power, 32'h0);
      deep_sleep <= 1'b0;
      tick(3);
      chk(cpu_hold, 32'h1);
      tick(20);
      chk(cpu_hold, 32'h0);
      $display("test sleep done");
   endtask
   task automatic t_samp;
      int on;
      fuse_drop_level <= 3'h2;
      for (int r = 0; r < 2; r++) begin
         boot(2'h2, 2'h0, r[0]);
         chk(drop_level_code, 32'h2);
         tick(20);
         on = 0;
         // A window of whole periods holds the same on-time wherever it starts.
         repeat (160) begin
            @(posedge clk);
            on += int'(detector_power);
         end
         chk(on, r ? 32'd16 : 32'd32);
      end
      $display("test sampled done");
   endtask
   initial begin
      boot(2'h1, 2'h2, 1'b1);
      t_regs;
      t_watch;
      t_drop;
      t_sleep;
      t_samp;
      wrap_up;
   end
endmodule // brownout_monitor_control_bench
